//--- logic/lan_link_cfg.svh
// timing and sizing constants shared by both ends of the lan connect link
`ifndef LAN_LINK_CFG_SVH
`define LAN_LINK_CFG_SVH

// ----------------------------------------------------------------
// clock rates in mhz
// ----------------------------------------------------------------
`define LL_CLK_MHZ      100
`define LL_FAST_MHZ     50
`define LL_SLOW_MHZ     5

// ----------------------------------------------------------------
// line timing
// ----------------------------------------------------------------
`define LL_FILTER_NS    200
`define LL_RESET_US     500
`define LL_SYNC_MARGIN  3
`define LL_SOFT_RST_CYC 16

// ----------------------------------------------------------------
// counter widths
// ----------------------------------------------------------------
`define LL_CNT_W        24
`define LL_SOFT_W       5
`define LL_DIV_W        8

`endif

//--- logic/lan_link_pkg.sv
// state types for the lan connect link ends and the clock divider
package lan_link_pkg;
  `include "lan_link_cfg.svh"

  // ----------------------------------------------------------------
  // device end: decoder of the reset/sync line
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LINE_IDLE, LINE_HIGH, LINE_RESET} line_state_t;

  typedef struct packed {
    logic [2:0]             sync_ff;
    logic                   level;
    line_state_t            state;
    logic [`LL_CNT_W-1:0]   run_cnt;
    logic [`LL_SOFT_W-1:0]  soft_cnt;
    logic                   phy_reset;
    logic                   word_align;
  } phy_state_t;

  // ----------------------------------------------------------------
  // clock divider
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`LL_DIV_W-1:0]   cnt;
    logic                   clk_out;
    logic                   fast;
  } div_state_t;

  // ----------------------------------------------------------------
  // controller end: system side and link side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   sync_tgl;
    logic                   rst_level;
    logic [`LL_CNT_W-1:0]   hold_cnt;
    logic [2:0]             done_ff;
    logic                   sync_done;
  } ctrl_sys_t;

  typedef struct packed {
    logic [1:0]             tgl_ff;
    logic [1:0]             rst_ff;
    logic                   tgl_seen;
    logic                   line;
    logic                   done_tgl;
  } ctrl_link_t;
endpackage

//--- logic/lan_connect_link_if.sv
// the two wires of the lan connect link that this block manages
`timescale 1ns/100ps
interface lan_connect_link_if;
  // the six data pins of the eight-pin link are carried elsewhere
  logic link_interface_clock;   // driven by the device end
  logic reset_sync_line;        // driven by the controller end

  modport phy_end  (output link_interface_clock, input  reset_sync_line);
  modport ctrl_end (input  link_interface_clock, output reset_sync_line);
endinterface // lan_connect_link_if

//--- logic/clock_divider.sv
// glitch-free two-rate clock divider that never stops
`timescale 1ns/100ps
`include "lan_link_cfg.svh"
module clock_divider #(
  parameter int HALF_FAST = 1,
  parameter int HALF_SLOW = 10
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // rate select
  input  wire logic sel_fast,
  // divided clock
  output logic      clk_out,
  output logic      fast
);
  import lan_link_pkg::*;

  div_state_t cur;
  div_state_t next;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  if (HALF_FAST < 1 || HALF_SLOW < 1 || HALF_SLOW >= (1 << `LL_DIV_W)) begin : g_bad_half
    $error("clock_divider: half periods out of range");
  end

  localparam logic [`LL_DIV_W-1:0] LAST_FAST = `LL_DIV_W'(HALF_FAST - 1);
  localparam logic [`LL_DIV_W-1:0] LAST_SLOW = `LL_DIV_W'(HALF_SLOW - 1);

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // rate changes only at a falling edge, so no half period is ever cut short
  always_comb begin
    next = cur;
    if (cur.cnt >= (cur.fast ? LAST_FAST : LAST_SLOW)) begin
      next.cnt     = '0;
      next.clk_out = ~cur.clk_out;
      if (cur.clk_out) begin
        next.fast = sel_fast;
      end
    end else begin
      next.cnt = cur.cnt + `LL_DIV_W'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next;
    end
  end

  assign clk_out = cur.clk_out;
  assign fast    = cur.fast;
endmodule // clock_divider

//--- logic/phy_link_end.sv
// device end of the lan connect link: link clock source and reset/sync decoder
`timescale 1ns/100ps
`include "lan_link_cfg.svh"

module phy_link_end #(
  parameter int RESET_CYC = `LL_RESET_US * `LL_CLK_MHZ
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // link toward the controller
  lan_connect_link_if.phy_end link,
  // operating mode from the phy core
  input  wire logic          speed_100,
  input  wire logic          low_power,
  input  wire logic          soft_reset_req,
  // results toward the phy core
  output logic               phy_reset,
  output logic               word_align,
  output logic               clock_fast
);
  import lan_link_pkg::*;

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  // least width that may count as a reset, rounded up
  localparam int FILTER_CYC = (`LL_FILTER_NS * `LL_CLK_MHZ + 999) / 1000;
  localparam int HALF_FAST  = `LL_CLK_MHZ / (2 * `LL_FAST_MHZ);
  localparam int HALF_SLOW  = `LL_CLK_MHZ / (2 * `LL_SLOW_MHZ);
  // a sync pulse is one link clock wide; allow for synchroniser skew
  localparam int SYNC_FAST  = 2 * HALF_FAST + `LL_SYNC_MARGIN;
  localparam int SYNC_SLOW  = 2 * HALF_SLOW + `LL_SYNC_MARGIN;

  localparam logic [`LL_CNT_W-1:0]  SYNC_MAX_FAST = `LL_CNT_W'(SYNC_FAST);
  localparam logic [`LL_CNT_W-1:0]  SYNC_MAX_SLOW = `LL_CNT_W'(SYNC_SLOW);
  localparam logic [`LL_CNT_W-1:0]  RESET_LAST    = `LL_CNT_W'(RESET_CYC - 1);
  localparam logic [`LL_CNT_W-1:0]  CNT_ONE       = `LL_CNT_W'(1);
  localparam logic [`LL_SOFT_W-1:0] SOFT_LEN      = `LL_SOFT_W'(`LL_SOFT_RST_CYC);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RESET_CYC <= SYNC_SLOW || RESET_CYC <= FILTER_CYC) begin : g_bad_reset
    $error("phy_link_end: reset length must exceed the sync and filter widths");
  end
  if (RESET_CYC >= (1 << `LL_CNT_W)) begin : g_bad_width
    $error("phy_link_end: reset length does not fit the run counter");
  end
  if (`LL_SOFT_RST_CYC >= (1 << `LL_SOFT_W) || `LL_SOFT_RST_CYC < 1) begin : g_bad_soft
    $error("phy_link_end: soft reset length does not fit its counter");
  end
  // whole half periods only: a remainder would put the link clock off rate
  if (HALF_FAST < 1 || 2 * HALF_FAST * `LL_FAST_MHZ != `LL_CLK_MHZ) begin : g_bad_fast
    $error("phy_link_end: system clock cannot make the fast link clock");
  end
  if (2 * HALF_SLOW * `LL_SLOW_MHZ != `LL_CLK_MHZ) begin : g_bad_slow
    $error("phy_link_end: system clock cannot make the slow link clock");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  phy_state_t                cur;
  phy_state_t                next;
  logic                      div_fast;
  logic                      div_clk;
  logic                      sel_fast;
  logic [`LL_CNT_W-1:0]      sync_max;

  // ----------------------------------------------------------------
  // link clock generation
  // ----------------------------------------------------------------
  // reduced power forces the slow rate whatever the link speed
  assign sel_fast = speed_100 & ~low_power;

  // ----------------------------------------------------------------
  // link clock divider
  // ----------------------------------------------------------------
  // the divider runs from rst_b only, so no line reset can stall the clock
  clock_divider #(
    .HALF_FAST (HALF_FAST),
    .HALF_SLOW (HALF_SLOW)
  ) i_clock_divider (
    .clk      (clk),
    .rst_b    (rst_b),
    .sel_fast (sel_fast),
    .clk_out  (div_clk),
    .fast     (div_fast)
  );

  // the device is the only source of the link clock
  assign link.link_interface_clock = div_clk;

  // ----------------------------------------------------------------
  // sync window
  // ----------------------------------------------------------------
  // the sync window follows the rate that is actually on the wire
  assign sync_max = div_fast ? SYNC_MAX_FAST : SYNC_MAX_SLOW;

  // ----------------------------------------------------------------
  // reset/sync line decoder
  // ----------------------------------------------------------------
  // the line is only ever read here, never driven: the controller owns it
  // timing: the filtered level trails the pin by three to four clocks,
  // and a high run is measured on the filtered level, so
  //  - up to one link clock plus the margin: a word alignment pulse
  //  - from there up to the reset length: nothing at all
  //  - the full reset length: reset, held until the line drops
  // the middle band is left alone on purpose: the controller gives no
  // promise about it, and guessing would risk a false reset
  always_comb begin
    next = cur;
    // three-stage synchroniser; first stage feeds only the second
    next.sync_ff = {cur.sync_ff[1:0], link.reset_sync_line};
    // a change counts once the second and third stages agree
    if (cur.sync_ff[1] == cur.sync_ff[2]) begin
      next.level = cur.sync_ff[2];
    end
    next.word_align = 1'b0;

    case (cur.state)
      LINE_IDLE: begin
        if (cur.level) begin
          next.state   = LINE_HIGH;
          next.run_cnt = CNT_ONE;
        end
      end
      LINE_HIGH: begin
        if (!cur.level) begin
          // a short pulse aligns word boundaries, never resets
          if (cur.run_cnt <= sync_max) begin
            next.word_align = 1'b1;
          end
          // anything under the filter width or up to 500 us ends here
          next.state = LINE_IDLE;
        end else if (cur.run_cnt >= RESET_LAST) begin
          // held past one clock and as long as 500 us: a reset
          next.state = LINE_RESET;
        end else begin
          next.run_cnt = cur.run_cnt + CNT_ONE;
        end
      end
      LINE_RESET: begin
        // internal reset stays until the controller lets go
        if (!cur.level) begin
          next.state = LINE_IDLE;
        end
      end
      default: begin
        next.state = LINE_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // management-register reset
    // ----------------------------------------------------------------
    // a fixed-length pulse so the core sees the same reset either way
    // a request while the count runs restarts it rather than adding to it
    if (soft_reset_req) begin
      next.soft_cnt = SOFT_LEN;
    end else if (cur.soft_cnt != '0) begin
      next.soft_cnt = cur.soft_cnt - `LL_SOFT_W'(1);
    end

    // both sources merge into one registered reset toward the phy core; the link clock divider does not take it
    next.phy_reset = (next.state == LINE_RESET) || (next.soft_cnt != '0);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{
        sync_ff:    '0,
        level:      1'b0,
        state:      LINE_IDLE,
        run_cnt:    '0,
        soft_cnt:   '0,
        phy_reset:  1'b0,
        word_align: 1'b0
      };
    end else begin
      cur <= next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign phy_reset  = cur.phy_reset;
  assign word_align = cur.word_align;
  // the rate flag is the divider's own flop, so it matches the wire
  assign clock_fast = div_fast;
endmodule // phy_link_end

//--- logic/ctrl_link_end.sv
// controller end of the lan connect link: drives the reset/sync line
`timescale 1ns/100ps
`include "lan_link_cfg.svh"
module ctrl_link_end #(
  parameter int HOLD_CYC = `LL_RESET_US * `LL_CLK_MHZ
) (
  // system clock and reset
  input  wire logic           clk,
  input  wire logic           rst_b,
  // link toward the device
  lan_connect_link_if.ctrl_end link,
  // requests from the controller core
  input  wire logic           sync_req,
  input  wire logic           reset_req,
  // status toward the controller core
  output logic                sync_done,
  output logic                reset_busy
);
  import lan_link_pkg::*;

  if (HOLD_CYC < 2 || HOLD_CYC >= (1 << `LL_CNT_W)) begin : g_bad_hold
    $error("ctrl_link_end: reset hold length out of range");
  end

  localparam logic [`LL_CNT_W-1:0] HOLD_LAST = `LL_CNT_W'(HOLD_CYC - 1);

  ctrl_sys_t  scur;
  ctrl_sys_t  snext;
  ctrl_link_t lcur;
  ctrl_link_t lnext;
  logic       pending;

  // ----------------------------------------------------------------
  // system side
  // ----------------------------------------------------------------
  // one sync in flight at a time, so two pulses never merge into a long one
  assign pending = scur.sync_tgl != scur.done_ff[2];

  always_comb begin
    snext           = scur;
    snext.done_ff   = {scur.done_ff[1:0], lcur.done_tgl};
    snext.sync_done = scur.done_ff[1] != scur.done_ff[2];
    if (sync_req && !pending && !scur.rst_level) begin
      snext.sync_tgl = ~scur.sync_tgl;
    end
    // the hold is counted here; the link side shifts the whole level
    if (reset_req && !scur.rst_level) begin
      snext.rst_level = 1'b1;
      snext.hold_cnt  = HOLD_LAST;
    end else if (scur.rst_level) begin
      if (scur.hold_cnt == '0) begin
        snext.rst_level = 1'b0;
      end else begin
        snext.hold_cnt = scur.hold_cnt - `LL_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scur <= '0;
    end else begin
      scur <= snext;
    end
  end

  // ----------------------------------------------------------------
  // link side, on the clock that the device drives
  // ----------------------------------------------------------------
  // the line changes only on link clock edges, so a sync is one clock wide
  always_comb begin
    lnext        = lcur;
    lnext.tgl_ff = {lcur.tgl_ff[0], scur.sync_tgl};
    lnext.rst_ff = {lcur.rst_ff[0], scur.rst_level};
    lnext.line   = lcur.rst_ff[1];
    if (lcur.tgl_ff[1] != lcur.tgl_seen) begin
      lnext.tgl_seen = lcur.tgl_ff[1];
      lnext.done_tgl = ~lcur.done_tgl;
      lnext.line     = 1'b1;
    end
  end

  always_ff @(posedge link.link_interface_clock or negedge rst_b) begin
    if (!rst_b) begin
      lcur <= '0;
    end else begin
      lcur <= lnext;
    end
  end

  assign link.reset_sync_line = lcur.line;
  assign sync_done            = scur.sync_done;
  assign reset_busy           = scur.rst_level;
endmodule // ctrl_link_end

//--- tb/lan_link_reset_sync_clock_asserts.sv
// concurrent checks on the lan connect link wires and the device end outputs
`timescale 1ns/100ps
module lan_link_reset_sync_clock_asserts #(
  parameter int RESET_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link wires
  input wire logic link_interface_clock,
  input wire logic reset_sync_line,
  // device end
  input wire logic speed_100,
  input wire logic low_power,
  input wire logic soft_reset_req,
  input wire logic phy_reset,
  input wire logic word_align,
  input wire logic clock_fast
);
  logic [15:0] run;   // samples of line high, saturating
  logic [15:0] last;  // length of the previous high run
  logic [3:0]  flat;  // samples the link clock stood still
  logic        q;     // link clock one sample back

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // saturate so a stuck clock or line never wraps back to a legal value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run  <= 16'h0000;
      last <= 16'h0000;
      flat <= 4'h0;
      q    <= 1'b0;
    end else begin
      run  <= !reset_sync_line ? 16'h0000 : (run == 16'hFFFF ? run : run + 16'h0001);
      last <= (!reset_sync_line && run != 16'h0000) ? run : last;
      flat <= (link_interface_clock != q) ? 4'h0 : (flat == 4'hF ? flat : flat + 4'h1);
      q    <= link_interface_clock;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_clk_runs; flat < 4'hC; endproperty
  a_clk_runs: assert property (p_clk_runs) else $error("link clock stood still");
  property p_fast_rate; clock_fast [*3] |-> $changed(link_interface_clock); endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("fast link clock missed a toggle");
  property p_slow_rate; $rose(link_interface_clock) && !clock_fast |=> $stable(link_interface_clock) [*8]; endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow link clock half period short");
  property p_low_power; $rose(low_power) |-> ##[0:24] !clock_fast; endproperty
  a_low_power: assert property (p_low_power) else $error("reduced power kept fast clock");
  property p_speed_up; $rose(speed_100) && !low_power |-> ##[0:24] clock_fast; endproperty
  a_speed_up: assert property (p_speed_up) else $error("fast mode did not speed up clock");
  property p_soft; soft_reset_req |=> phy_reset; endproperty
  a_soft: assert property (p_soft) else $error("soft request gave no reset");
  property p_hold; phy_reset && reset_sync_line |=> phy_reset; endproperty
  a_hold: assert property (p_hold) else $error("reset dropped while line high");
  property p_long_reset; run == RESET_CYC + 8 |-> phy_reset; endproperty
  a_long_reset: assert property (p_long_reset) else $error("long line high gave no reset");
  property p_no_short_reset; $rose(phy_reset) |-> $past(soft_reset_req) || run > 16'h0014; endproperty
  a_no_short_reset: assert property (p_no_short_reset) else $error("reset without cause");
  property p_sync; $fell(reset_sync_line) && run <= 16'h0014 |-> ##[2:8] word_align; endproperty
  a_sync: assert property (p_sync) else $error("short pulse gave no alignment");
  property p_no_align; $rose(word_align) |-> last <= 16'h001A; endproperty
  a_no_align: assert property (p_no_align) else $error("alignment after long high run");
endmodule // lan_link_reset_sync_clock_asserts

//--- tb/lan_link_reset_sync_clock_tb.sv
// self-checking bench for both ends of the lan connect link
`timescale 1ns/100ps
`include "lan_link_cfg.svh"
module lan_link_reset_sync_clock_tb;
  localparam int RST_CYC = 200;  // shortened, above the slow sync window
  localparam int HOLD    = 300;  // controller hold, beyond the device count
  logic clk, rst_b, speed_100, low_power, soft_reset_req, sync_req, reset_req;
  logic phy_reset, word_align, clock_fast, sync_done, reset_busy;
  int   n_fail = 0, checks_done = 0, n_align = 0, n_rst = 0, n_done = 0, k = 0;

  lan_connect_link_if link ();
  phy_link_end #(.RESET_CYC(RST_CYC)) i_phy_link_end (.clk(clk), .rst_b(rst_b), .link(link.phy_end),
    .speed_100(speed_100), .low_power(low_power), .soft_reset_req(soft_reset_req),
    .phy_reset(phy_reset), .word_align(word_align), .clock_fast(clock_fast));
  ctrl_link_end #(.HOLD_CYC(HOLD)) i_ctrl_link_end (.clk(clk), .rst_b(rst_b), .link(link.ctrl_end),
    .sync_req(sync_req), .reset_req(reset_req), .sync_done(sync_done), .reset_busy(reset_busy));
  lan_link_reset_sync_clock_asserts #(.RESET_CYC(RST_CYC)) i_lan_link_reset_sync_clock_asserts (
    .clk(clk), .rst_b(rst_b), .link_interface_clock(link.link_interface_clock),
    .reset_sync_line(link.reset_sync_line), .speed_100(speed_100), .low_power(low_power),
    .soft_reset_req(soft_reset_req), .phy_reset(phy_reset), .word_align(word_align),
    .clock_fast(clock_fast));

  // clock and event counters, sampled away from the launching edge
  always #5 clk = ~clk;
  always @(negedge clk) begin
    if (word_align === 1'b1) n_align++;
    if (phy_reset === 1'b1) n_rst++;
    if (sync_done === 1'b1) n_done++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // v is {sync_req, reset_req, soft_reset_req}, held for len cycles
  task automatic pulse(input logic [2:0] v, input int len);
    @(posedge clk);
    {sync_req, reset_req, soft_reset_req} <= v;
    repeat (len) @(posedge clk);
    {sync_req, reset_req, soft_reset_req} <= 3'h0;
  endtask

  task automatic wait_for(input string nm, input logic lvl, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if ((nm == "sync_done" ? sync_done : reset_busy) === lvl) return;
    end
    n_fail++;
    $display("MISMATCH %s expected %0h seen timeout", nm, lvl);
    stop_test();
  endtask

  // count link clock changes over 200 system clocks
  task automatic rate(input string nm, input logic [31:0] exp);
    logic q;
    int   c;
    @(negedge clk);
    q = link.link_interface_clock;
    c = 0;
    repeat (200) begin
      @(negedge clk);
      if (link.link_interface_clock !== q) c++;
      q = link.link_interface_clock;
    end
    chk(nm, exp, c);
  endtask

  // a request held two cycles must still give a single pulse
  task automatic sync_test(input int len);
    int a, r;
    a = n_align;
    r = n_rst;
    pulse(3'h4, len);
    wait_for("sync_done", 1'b1, 120);
    repeat (40) @(negedge clk);
    chk("word_align count", 1, n_align - a);
    chk("reset cycles", 0, n_rst - r);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, rst_b, speed_100, low_power, soft_reset_req, sync_req, reset_req} = 7'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset outputs", 0, {phy_reset, word_align, clock_fast, sync_done, reset_busy});
    rate("slow clock", 20);
    $display("test reset and slow clock done");
    @(posedge clk);
    speed_100 <= 1'b1;
    repeat (40) @(negedge clk);
    chk("clock_fast", 1, clock_fast);
    rate("fast clock", 200);
    sync_test(1);
    sync_test(2);
    $display("test fast sync done");
    @(posedge clk);
    low_power <= 1'b1;
    repeat (40) @(negedge clk);
    chk("clock_fast low power", 0, clock_fast);
    rate("low power clock", 20);
    sync_test(1);
    @(posedge clk);
    low_power <= 1'b0;
    repeat (40) @(negedge clk);
    $display("test low power done");
    // long hold: a sync asked for meanwhile is refused
    k = n_done;
    begin
      int a, r;
      a = n_align;
      r = n_rst;
      pulse(3'h2, 1);
      @(negedge clk);
      chk("reset_busy", 1, reset_busy);
      pulse(3'h4, 1);
      wait_for("reset_busy", 1'b0, HOLD + 10);
      repeat (100) @(negedge clk);
      chk("phy_reset seen", 1, (n_rst - r) > 50);
      chk("phy_reset released", 0, phy_reset);
      chk("align after reset", 0, n_align - a);
      chk("sync during hold", 0, n_done - k);
    end
    $display("test line reset done");
    // soft reset, single and restarted by a second request
    for (int len = 1; len <= 2; len++) begin
      k = n_rst;
      pulse(3'h1, len);
      repeat (30) @(negedge clk);
      chk("soft reset cycles", `LL_SOFT_RST_CYC - 1 + len, n_rst - k);
    end
    $display("test soft reset done");
    stop_test();
  end
endmodule // lan_link_reset_sync_clock_tb
